// [design/odsc_pkg.sv]
// Constants shared by the eight-channel converter control logic
`default_nettype none
package odsc_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [3:0] ADDR_NOP = 4'h0;
  localparam logic [3:0] ADDR_IDENTITY = 4'h1;
  localparam logic [3:0] ADDR_MODE = 4'h2;
  localparam logic [3:0] ADDR_CONFIG = 4'h3;
  localparam logic [3:0] ADDR_GAIN = 4'h4;
  localparam logic [3:0] ADDR_TRIGGER = 4'h5;
  localparam logic [3:0] ADDR_BCAST = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_CODE0 = 4'h8;
  // ==========================================================
  // Frame layout, on the 24-bit command word
  localparam logic [5:0] FRAME_SHORT = 6'h18;
  localparam logic [5:0] FRAME_LONG = 6'h20;
  localparam int RW_BIT = 23;
  localparam int ERR_BIT = 22;
  localparam int ADDR_HI = 19;
  localparam int ADDR_LO = 16;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // ==========================================================
  // Field positions
  localparam int CFG_ALERT_SEL = 13;
  localparam int CFG_ALERT_EN = 12;
  localparam int CFG_CRC_EN = 11;
  localparam int CFG_EARLY = 10;
  localparam int CFG_ODIS = 9;
  localparam int CFG_REF_OFF = 8;
  localparam int GAIN_DIV_BIT = 8;
  localparam int TRIG_LOAD_BIT = 4;
  localparam logic [3:0] SOFT_RESET_KEY = 4'ha;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h3fff;
  localparam logic [15:0] GAIN_WRITE_MASK = 16'h01ff;
  // ==========================================================
  // Reset values and identity fields
  localparam logic [15:0] MODE_RESET = 16'hff00;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] GAIN_RESET_ZERO = 16'h0000;
  localparam logic [15:0] GAIN_RESET_MID = 16'h00ff;
  localparam logic [15:0] CODE_RESET_ZERO = 16'h0000;
  localparam logic [15:0] CODE_RESET_MID = 16'h8000;
  localparam logic [15:0] BCAST_RESET = 16'h0000;
  localparam logic [2:0] ID_RES_16 = 3'h0;
  localparam logic [3:0] ID_CHANNELS = 4'h8;
  // ==========================================================
  // Frame tracking states
  typedef enum logic [1:0] {
    FRAME_IDLE = 2'b01,
    FRAME_SHIFT = 2'b10
  } odsc_frame_e;
endpackage : odsc_pkg
`default_nettype wire

// [design/odsc_sync.sv]
// Two-stage synchroniser for pin inputs
`default_nettype none
module odsc_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] first_stage;

  // First stage feeds only the second stage
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      first_stage <= '0;
      sync_out <= '0;
    end else if (enable) begin
      first_stage <= async_in;
      sync_out <= first_stage;
    end
  end
endmodule : odsc_sync
`default_nettype wire

// [design/odsc_crc8.sv]
// CRC-8 over a 24-bit word, zero initial value, MSB first
`default_nettype none
module odsc_crc8 (
  // Data
  input wire logic [23:0] data,
  output logic [7:0] crc
);
  always_comb begin
    logic fb;
    fb = 1'b0;
    crc = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      fb = crc[7] ^ data[i];
      crc = {crc[6:0], 1'b0} ^ (fb ? odsc_pkg::CRC_POLY : 8'h00);
    end
  end
endmodule : odsc_crc8
`default_nettype wire

// [design/odsc_control.sv]
// Serial control logic of the eight-channel voltage-output converter
`default_nettype none
module odsc_control #(
  parameter int CHANNELS = 8,
  parameter logic midscale_reset = 1'b0,
  parameter logic [4:0] identity_field = 5'h00,  // Arbitrary value
  parameter logic [1:0] revision_field = 2'h1    // Arbitrary value
) (
  // Clock, reset, enable
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  // Serial link pins
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out_or_alert_out,
  output logic serial_out_or_alert_oe,
  // Analog side status
  input wire logic reference_alarm_flag,
  // Analog side controls
  output logic [CHANNELS*16-1:0] channel_code_active,
  output logic [CHANNELS-1:0] channel_off,
  output logic [CHANNELS-1:0] buffer_double,
  output logic reference_on,
  output logic reference_divide
);
  // ==========================================================
  // Pin synchronisation and edge detection
  logic sclk_s, cs_n_s, sdi_s, ref_alarm_s;
  logic cs_sel_s;
  logic sclk_d, cs_n_d;
  logic sclk_fall, sclk_rise, cs_fall, cs_rise;

  odsc_sync #(.WIDTH(4)) pin_sync (
    .clock(clock),
    .reset(reset),
    .enable(enable),
    .async_in({serial_clock, ~chip_select_n, serial_in, reference_alarm_flag}),
    .sync_out({sclk_s, cs_sel_s, sdi_s, ref_alarm_s})
  );

  // Select travels inverted so a chain fresh out of reset reads deselected, with no false frame edge
  assign cs_n_s = ~cs_sel_s;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
    end else if (enable) begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  assign sclk_fall = enable & sclk_d & ~sclk_s;
  assign sclk_rise = enable & ~sclk_d & sclk_s;
  assign cs_fall = enable & cs_n_d & ~cs_n_s;
  assign cs_rise = enable & ~cs_n_d & cs_n_s;

  // ==========================================================
  // Registers
  logic [15:0] mode_select, config_reg, gain, bcast;
  logic [15:0] buffer [CHANNELS];
  logic [15:0] active [CHANNELS];
  logic crc_err_flag;
  logic crc_en;
  assign crc_en = config_reg[odsc_pkg::CFG_CRC_EN];

  // ==========================================================
  // Frame capture
  odsc_pkg::odsc_frame_e frame_state;
  logic [31:0] shreg;
  logic [5:0] bit_count;
  logic [5:0] frame_len;
  logic [23:0] word, echo_word;
  logic [7:0] crc_calc, echo_crc;
  logic [3:0] addr;
  logic [15:0] wdata, readback;
  logic frame_done, crc_ok, accept, do_write, do_read, soft_reset, load_pulse;

  assign frame_len = crc_en ? odsc_pkg::FRAME_LONG : odsc_pkg::FRAME_SHORT;
  assign word = crc_en ? shreg[31:8] : shreg[23:0];

  odsc_crc8 check_crc (
    .data(shreg[31:8]),
    .crc(crc_calc)
  );

  odsc_crc8 reply_crc (
    .data(echo_word),
    .crc(echo_crc)
  );

  // Frame passes when the CRC over the 24-bit word equals the appended CRC byte
  assign crc_ok = ~crc_en | (crc_calc == shreg[7:0]);
  assign frame_done = cs_rise & (frame_state == odsc_pkg::FRAME_SHIFT) & (bit_count >= frame_len);
  assign accept = frame_done & crc_ok;
  assign do_write = accept & ~word[odsc_pkg::RW_BIT];
  assign do_read = accept & word[odsc_pkg::RW_BIT];
  assign addr = word[odsc_pkg::ADDR_HI:odsc_pkg::ADDR_LO];
  assign wdata = word[15:0];
  // A write of any value to the no-operation address decodes to nothing
  assign soft_reset = do_write & (addr == odsc_pkg::ADDR_TRIGGER) &
                      (wdata[3:0] == odsc_pkg::SOFT_RESET_KEY);
  assign load_pulse = do_write & (addr == odsc_pkg::ADDR_TRIGGER) & wdata[odsc_pkg::TRIG_LOAD_BIT];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_state <= odsc_pkg::FRAME_IDLE;
    end else if (cs_fall) begin
      frame_state <= odsc_pkg::FRAME_SHIFT;
    end else if (cs_rise) begin
      frame_state <= odsc_pkg::FRAME_IDLE;
    end
  end

  // Counter saturates so an overlong chain frame still counts as complete
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bit_count <= 6'h00;
    end else if (cs_fall || cs_rise) begin
      bit_count <= 6'h00;
    end else if (sclk_fall && frame_state == odsc_pkg::FRAME_SHIFT && bit_count != odsc_pkg::FRAME_LONG) begin
      bit_count <= bit_count + 6'h01;
    end
  end

  // Reply loads at frame open and is pushed out by incoming bits
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shreg <= 32'h0000_0000;
    end else if (cs_fall) begin
      shreg <= crc_en ? {echo_word, echo_crc} : {8'h00, echo_word};
    end else if (sclk_fall && frame_state == odsc_pkg::FRAME_SHIFT) begin
      shreg <= {shreg[30:0], sdi_s};
    end
  end

  // ==========================================================
  // Serial output
  logic sdo_bit;
  logic top_now, top_next;
  assign top_now = crc_en ? shreg[31] : shreg[23];
  assign top_next = crc_en ? shreg[30] : shreg[22];

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sdo_bit <= 1'b0;
    end else if (cs_fall) begin
      sdo_bit <= echo_word[23];
    end else if (frame_state == odsc_pkg::FRAME_SHIFT) begin
      if (config_reg[odsc_pkg::CFG_EARLY] && sclk_fall) begin
        sdo_bit <= top_next;
      end else if (!config_reg[odsc_pkg::CFG_EARLY] && sclk_rise) begin
        sdo_bit <= top_now;
      end
    end
  end

  // Alert mode turns the pin into an open-drain, active-low flag
  logic alert_level;
  assign alert_level = config_reg[odsc_pkg::CFG_ALERT_SEL] ? ref_alarm_s : crc_err_flag;
  always_comb begin
    if (config_reg[odsc_pkg::CFG_ALERT_EN]) begin
      serial_out_or_alert_out = 1'b0;
      serial_out_or_alert_oe = alert_level;
    end else begin
      serial_out_or_alert_out = sdo_bit;
      serial_out_or_alert_oe = ~config_reg[odsc_pkg::CFG_ODIS] & ~cs_n_s;
    end
  end

  // ==========================================================
  // Readback and reply word
  always_comb begin
    readback = 16'h0000;
    unique case (addr)
      odsc_pkg::ADDR_IDENTITY: readback = {1'b0, odsc_pkg::ID_RES_16, odsc_pkg::ID_CHANNELS,
                                           midscale_reset, identity_field, revision_field};
      odsc_pkg::ADDR_MODE: readback = mode_select;
      odsc_pkg::ADDR_CONFIG: readback = config_reg;
      odsc_pkg::ADDR_GAIN: readback = gain;
      odsc_pkg::ADDR_BCAST: readback = bcast;
      odsc_pkg::ADDR_STATUS: readback = {15'h0000, ref_alarm_s};
      default: begin
        if (addr >= odsc_pkg::ADDR_CODE0) begin
          readback = buffer[addr[2:0]];
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      echo_word <= 24'h00_0000;
      crc_err_flag <= 1'b0;
    end else if (soft_reset) begin
      echo_word <= 24'h00_0000;
      crc_err_flag <= 1'b0;
    end else if (frame_done) begin
      echo_word <= {word[23], ~crc_ok, word[21:16],
                    do_read ? readback : wdata};
      crc_err_flag <= ~crc_ok;
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_select <= odsc_pkg::MODE_RESET;
      config_reg <= odsc_pkg::CFG_RESET;
      gain <= midscale_reset ? odsc_pkg::GAIN_RESET_MID : odsc_pkg::GAIN_RESET_ZERO;
      bcast <= odsc_pkg::BCAST_RESET;
    end else if (soft_reset) begin
      mode_select <= odsc_pkg::MODE_RESET;
      config_reg <= odsc_pkg::CFG_RESET;
      gain <= midscale_reset ? odsc_pkg::GAIN_RESET_MID : odsc_pkg::GAIN_RESET_ZERO;
      bcast <= odsc_pkg::BCAST_RESET;
    end else if (do_write) begin
      if (addr == odsc_pkg::ADDR_MODE) begin
        mode_select <= wdata;
      end
      if (addr == odsc_pkg::ADDR_CONFIG) begin
        config_reg <= wdata & odsc_pkg::CFG_WRITE_MASK;
      end
      if (addr == odsc_pkg::ADDR_GAIN) begin
        gain <= wdata & odsc_pkg::GAIN_WRITE_MASK;
      end
      if (addr == odsc_pkg::ADDR_BCAST) begin
        bcast <= wdata;
      end
    end
  end

  assign channel_off = config_reg[CHANNELS-1:0];
  assign reference_on = ~config_reg[odsc_pkg::CFG_REF_OFF];
  assign reference_divide = gain[odsc_pkg::GAIN_DIV_BIT];
  assign buffer_double = gain[CHANNELS-1:0];

  // ==========================================================
  // Channel buffer and active codes
  logic [15:0] code_reset;
  assign code_reset = midscale_reset ? odsc_pkg::CODE_RESET_MID : odsc_pkg::CODE_RESET_ZERO;

  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    logic hit;
    assign hit = do_write & (addr == odsc_pkg::ADDR_CODE0 + 4'(i));

    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        buffer[i] <= midscale_reset ? odsc_pkg::CODE_RESET_MID : odsc_pkg::CODE_RESET_ZERO;
      end else if (soft_reset) begin
        buffer[i] <= code_reset;
      end else if (hit) begin
        buffer[i] <= wdata;
      end
    end

    // Broadcast outranks a same-frame trigger since one frame carries one address
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        active[i] <= odsc_pkg::CODE_RESET_ZERO;
      end else if (soft_reset) begin
        active[i] <= code_reset;
      end else if (do_write && addr == odsc_pkg::ADDR_BCAST && mode_select[8+i]) begin
        active[i] <= wdata;
      end else if (hit && !mode_select[i]) begin
        active[i] <= wdata;
      end else if (load_pulse && mode_select[i]) begin
        active[i] <= buffer[i];
      end
    end

    assign channel_code_active[i*16 +: 16] = active[i];
  end

  // ==========================================================
  // Checks
  async_update_a: assert property (@(posedge clock) disable iff (reset)
    (do_write && addr == odsc_pkg::ADDR_CODE0 && !mode_select[0]) |=> active[0] == $past(wdata))
    else $error("asynchronous channel did not take the code");
  sync_hold_a: assert property (@(posedge clock) disable iff (reset)
    (do_write && addr == odsc_pkg::ADDR_CODE0 && mode_select[0]) |=> active[0] == $past(active[0]))
    else $error("synchronous channel changed without trigger");
  trigger_load_a: assert property (@(posedge clock) disable iff (reset)
    (load_pulse && mode_select[1] && !soft_reset) |=> active[1] == $past(buffer[1]))
    else $error("trigger did not load synchronous channel");
  broadcast_load_a: assert property (@(posedge clock) disable iff (reset)
    (do_write && addr == odsc_pkg::ADDR_BCAST && mode_select[15]) |=> active[7] == bcast)
    else $error("broadcast member missed the value");
  crc_discard_a: assert property (@(posedge clock) disable iff (reset)
    (frame_done && !crc_ok) |=> ($stable(config_reg) && $stable(mode_select) && $stable(bcast)))
    else $error("failed frame changed a register");
  soft_reset_a: assert property (@(posedge clock) disable iff (reset)
    soft_reset |=> (mode_select == odsc_pkg::MODE_RESET && config_reg == odsc_pkg::CFG_RESET))
    else $error("soft reset left a register changed");
  short_frame_a: assert property (@(posedge clock) disable iff (reset)
    (cs_rise && bit_count < frame_len) |-> !do_write ##1 $stable(config_reg))
    else $error("short frame was decoded");
  output_release_a: assert property (@(posedge clock) disable iff (reset)
    (!config_reg[odsc_pkg::CFG_ALERT_EN] && (config_reg[odsc_pkg::CFG_ODIS] || cs_n_s))
      |-> !serial_out_or_alert_oe)
    else $error("serial output driven while released");
  counter_restart_a: assert property (@(posedge clock) disable iff (reset)
    cs_rise |=> bit_count == 6'h00)
    else $error("bit counter not restarted");
  read_echo_a: assert property (@(posedge clock) disable iff (reset)
    (do_read && addr == odsc_pkg::ADDR_CONFIG) |=> echo_word[15:0] == $past(config_reg))
    else $error("read reply lost register contents");
endmodule : odsc_control
`default_nettype wire

// [verif/odsc_host_model.sv]
// Host serial master model for the converter link
`default_nettype none
module odsc_host_model (
  // Link pins
  output logic serial_clock,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_line,
  input wire logic line_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic oe_seen;
  // ==========================================================
  // Idle state
  // Clock stands high between frames so the first edge of a frame is a fall
  initial begin
    serial_clock = 1'b1;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
    oe_seen = 1'b0;
  end
  // ==========================================================
  // One frame, MSB first, answer sampled on the same falls
  task automatic xfer(input logic [63:0] word, input int nbits, output logic [63:0] reply);
    reply = '0;
    oe_seen = 1'b0;
    chip_select_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_in = word[i];
      #62.5;
      serial_clock = 1'b0;
      reply = {reply[62:0], serial_line};
      oe_seen = oe_seen | line_oe;
      #62.5;
      serial_clock = 1'b1;
    end
    #62.5;
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    // Long gap lets register effects land before the next frame
    #250;
  endtask : xfer
endmodule : odsc_host_model
`default_nettype wire

// [verif/odsc_control_tb.sv]
// Self-checking bench of the converter serial control logic
`default_nettype none
module odsc_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset, enable, sclk, cs_n, sdi, out_bit, out_oe, alarm, last_bit, line;
  logic [127:0] active;
  logic [7:0] ch_off, buf_dbl;
  logic ref_on, ref_div, crc_on;
  logic [63:0] rep;
  logic [15:0] rd_val;
  int bad_count, n_checks;
  localparam logic [4:0] ID_CODE = 5'h0c; // Arbitrary value
  odsc_control #(.identity_field(ID_CODE)) uut (
    .clock(clock), .reset(reset), .enable(enable),
    .serial_clock(sclk), .chip_select_n(cs_n), .serial_in(sdi),
    .serial_out_or_alert_out(out_bit), .serial_out_or_alert_oe(out_oe),
    .reference_alarm_flag(alarm), .channel_code_active(active), .channel_off(ch_off),
    .buffer_double(buf_dbl), .reference_on(ref_on), .reference_divide(ref_div)
  );
  odsc_host_model host (
    .serial_clock(sclk), .chip_select_n(cs_n), .serial_in(sdi),
    .serial_line(line), .line_oe(out_oe)
  );
  // Released pin shows the inverse of its last value, never stale data
  always @(posedge clock) if (out_oe) last_bit <= out_bit;
  assign line = out_oe ? out_bit : ~last_bit;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==========================================================
  // Helpers
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic frame(input logic rw, input logic [3:0] a, input logic [15:0] d, input logic bad);
    logic [23:0] w;
    w = {rw, 3'h0, a, d};
    if (crc_on) host.xfer({32'h0, w, crc8(w) ^ {7'h0, bad}}, 32, rep);
    else host.xfer({40'h0, w}, 24, rep);
  endtask : frame
  task automatic rd(input logic [3:0] a);
    frame(1'b1, a, 16'h0000, 1'b0);
    frame(1'b0, odsc_pkg::ADDR_NOP, 16'h0000, 1'b0);
    rd_val = crc_on ? rep[23:8] : rep[15:0];
  endtask : rd
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  // ==========================================================
  // Scenarios
  task automatic t_defaults;
    chk("codes zero", 32'h1, {31'h0, active === 128'h0});
    chk("power", 32'h0001_0000, {14'h0, ref_div, ref_on, ch_off, buf_dbl});
    rd(odsc_pkg::ADDR_MODE);
    chk("mode", 32'hff00, {16'h0, rd_val});
    rd(odsc_pkg::ADDR_IDENTITY);
    chk("identity", {16'h0, 4'h0, 4'h8, 1'b0, ID_CODE, 2'h1}, {16'h0, rd_val});
    rd(odsc_pkg::ADDR_TRIGGER);
    chk("trigger read", 32'h0, {16'h0, rd_val});
  endtask : t_defaults
  task automatic t_async;
    frame(1'b0, odsc_pkg::ADDR_CODE0, 16'h1234, 1'b0);
    chk("ch0 active", 32'h1234, {16'h0, active[15:0]});
    chk("idle oe", 32'h0, {31'h0, out_oe});
    frame(1'b0, odsc_pkg::ADDR_NOP, 16'h0000, 1'b0);
    chk("echo", 32'h0008_1234, {8'h0, rep[23:0]});
    chk("frame oe", 32'h1, {31'h0, host.oe_seen});
    rd(odsc_pkg::ADDR_CODE0);
    chk("ch0 buffer", 32'h1234, {16'h0, rd_val});
  endtask : t_async
  task automatic t_sync;
    frame(1'b0, odsc_pkg::ADDR_MODE, 16'hff03, 1'b0);
    frame(1'b0, 4'h8, 16'h5678, 1'b0);
    frame(1'b0, 4'h9, 16'habcd, 1'b0);
    chk("sync held", {16'h0000, 16'h1234}, active[31:0]);
    rd(4'h9);
    chk("ch1 buffer", 32'habcd, {16'h0, rd_val});
    frame(1'b0, odsc_pkg::ADDR_TRIGGER, 16'h0010, 1'b0);
    chk("sync loaded", 32'habcd_5678, active[31:0]);
  endtask : t_sync
  task automatic t_bcast;
    // Members ch0, ch2 and ch7; ch0 and ch1 stay synchronous
    frame(1'b0, odsc_pkg::ADDR_MODE, 16'h8503, 1'b0);
    frame(1'b0, odsc_pkg::ADDR_BCAST, 16'h5a5a, 1'b0);
    chk("bcast ch0 ch1", 32'habcd_5a5a, active[31:0]);
    chk("bcast ch2", 32'h5a5a, {16'h0, active[47:32]});
    chk("bcast ch7", 32'h5a5a, {16'h0, active[127:112]});
  endtask : t_bcast
  task automatic t_config;
    frame(1'b0, odsc_pkg::ADDR_CONFIG, 16'hc181, 1'b0);
    frame(1'b0, odsc_pkg::ADDR_GAIN, 16'h01ff, 1'b0);
    chk("power set", 32'h0002_81ff, {14'h0, ref_div, ref_on, ch_off, buf_dbl});
    rd(odsc_pkg::ADDR_CONFIG);
    chk("config", 32'h0181, {16'h0, rd_val});
    frame(1'b0, odsc_pkg::ADDR_CONFIG, 16'h0200, 1'b0);
    frame(1'b0, odsc_pkg::ADDR_NOP, 16'h0000, 1'b0);
    chk("disabled oe", 32'h0, {31'h0, host.oe_seen});
    frame(1'b0, odsc_pkg::ADDR_CONFIG, 16'h0400, 1'b0);
    frame(1'b0, odsc_pkg::ADDR_NOP, 16'h0000, 1'b0);
    chk("early echo", 32'h0003_0400, {8'h0, rep[23:0]});
    // Reference alarm: status bit first, then the pin in alert mode
    @(negedge clock) alarm = 1'b1;
    rd(odsc_pkg::ADDR_STATUS);
    chk("alarm status", 32'h1, {16'h0, rd_val});
    frame(1'b0, odsc_pkg::ADDR_CONFIG, 16'h3000, 1'b0);
    chk("alert pin", 32'h2, {30'h0, out_oe, out_bit});
    @(negedge clock) alarm = 1'b0;
    repeat (4) @(negedge clock);
    chk("alert clear", 32'h0, {31'h0, out_oe});
    frame(1'b0, odsc_pkg::ADDR_CONFIG, 16'h0000, 1'b0);
  endtask : t_config
  task automatic t_extra;
    // Two devices' worth of clocks: only the last 24 bits decode
    host.xfer({16'h0, 24'h0c1111, 24'h0a2222}, 48, rep);
    chk("last word", 32'h2222, {16'h0, active[47:32]});
    chk("first word", 32'h0, {16'h0, active[79:64]});
    chk("pass through", 32'h000c_1111, {8'h0, rep[23:0]});
  endtask : t_extra
  task automatic t_crc;
    frame(1'b0, odsc_pkg::ADDR_CONFIG, 16'h0800, 1'b0);
    crc_on = 1'b1;
    frame(1'b0, 4'hd, 16'h4444, 1'b0);
    chk("crc good", 32'h4444, {16'h0, active[95:80]});
    frame(1'b0, 4'hd, 16'h7777, 1'b1);
    chk("crc bad", 32'h4444, {16'h0, active[95:80]});
    frame(1'b0, odsc_pkg::ADDR_NOP, 16'h0000, 1'b0);
    chk("error echo", {8'h4d, 16'h7777, crc8({8'h4d, 16'h7777})}, rep[31:0]);
    host.xfer({40'h0, 24'h0d0001}, 24, rep);
    chk("short frame", 32'h4444, {16'h0, active[95:80]});
    rd(4'hd);
    chk("read reply", {8'h8d, 16'h4444, crc8({8'h8d, 16'h4444})}, rep[31:0]);
    frame(1'b0, odsc_pkg::ADDR_TRIGGER, 16'h0005, 1'b0);
    rd(odsc_pkg::ADDR_CONFIG);
    chk("no reset", 32'h0800, {16'h0, rd_val});
    frame(1'b0, odsc_pkg::ADDR_TRIGGER, 16'h000a, 1'b0);
    crc_on = 1'b0;
    chk("reset codes", 32'h1, {31'h0, active === 128'h0});
    chk("reset power", 32'h0001_0000, {14'h0, ref_div, ref_on, ch_off, buf_dbl});
    rd(odsc_pkg::ADDR_MODE);
    chk("reset mode", 32'hff00, {16'h0, rd_val});
  endtask : t_crc
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    reset = 1'b1;
    enable = 1'b1;
    alarm = 1'b0;
    crc_on = 1'b0;
    last_bit = 1'b0;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    repeat (5) @(negedge clock);
    t_defaults;
    t_async;
    t_sync;
    t_bcast;
    t_config;
    t_extra;
    t_crc;
    close_out;
  end
  initial begin
    #900us;
    bad_count++;
    close_out;
  end
endmodule : odsc_control_tb
`default_nettype wire
